// >>> shared/usb_port_pkg.sv
// Package with the register map, field layout and timing constants of the indirect port.
package usb_port_pkg;

  // Special-function addresses of the two port registers.
  localparam logic [7:0] ADDR_PORT_SFR = 8'h96;
  localparam logic [7:0] DATA_PORT_SFR = 8'h97;

  // Field positions in the indirect address port.
  localparam int BUSY_BIT = 7;
  localparam int AUTO_READ_BIT = 6;
  localparam int TARGET_MSB = 5;

  // Internal register addresses.
  localparam logic [5:0] FUNC_ADDR_IDX = 6'h00;
  localparam logic [5:0] IN_FLAGS_IDX = 6'h02;
  localparam logic [5:0] OUT_FLAGS_IDX = 6'h04;
  localparam logic [5:0] COMMON_FLAGS_IDX = 6'h06;
  localparam logic [5:0] IN_ENABLES_IDX = 6'h07;
  localparam logic [5:0] OUT_ENABLES_IDX = 6'h09;
  localparam logic [5:0] COMMON_ENABLES_IDX = 6'h0B;
  localparam logic [5:0] EP_SELECT_IDX = 6'h0E;
  localparam logic [5:0] CLK_RECOVERY_IDX = 6'h0F;
  localparam logic [5:0] EP_ENABLE_IDX = 6'h1E;
  localparam logic [5:0] INDEXED_LO_IDX = 6'h11;
  localparam logic [5:0] INDEXED_HI_IDX = 6'h17;
  localparam logic [5:0] FIFO_LO_IDX = 6'h20;
  localparam logic [5:0] FIFO_HI_IDX = 6'h23;

  // Endpoint selector layout.
  localparam int EP_FIELD_MSB = 3;
  localparam logic [3:0] EP_LAST_CODE = 4'h3;
  localparam int NUM_EP = 4;

  // Clock recovery control layout and reset value.
  localparam int RECOVERY_EN_BIT = 7;
  localparam int SINGLE_STEP_BIT = 6;
  localparam int LOW_SPEED_REC_BIT = 5;
  localparam logic [7:0] CLK_RECOVERY_RESET = 8'h0F;

  // Transceiver control speed select bit.
  localparam int SPEED_BIT = 5;

  // Reset values.
  localparam logic [7:0] ZERO_BYTE = 8'h00;

  // Number of system cycles an access stays busy after being launched.
  localparam logic [1:0] ACCESS_CYCLES = 2'h2;

  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_READ = 2'b01,
    ST_WRITE = 2'b10
  } access_state_t;

  // One access toward the internal register space.
  typedef struct packed {
    logic write;
    logic read;
    logic [5:0] target;
    logic [7:0] data;
  } int_access_t;

  // Special-function register bus request.
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } sfr_req_t;

endpackage : usb_port_pkg

// >>> verification/tb_top.sv
// Self-checking testbench of the indirect register port.
`timescale 1ns/1ps

module tb_top;
  logic sys_clk = 1'b0;
  logic srst = 1'b1;
  usb_port_pkg::sfr_req_t sfr_req = '0;
  logic speed_select = 1'b0;
  logic [7:0] sfr_rdata;
  usb_port_pkg::int_access_t int_access;
  logic [7:0] int_rdata;
  logic [1:0] endpoint_index;
  logic indexed_access;
  logic [3:0] fifo_strobe;
  logic [5:0] target_class;
  logic full_speed;
  logic recovery_enable;
  logic single_step_calibrate;
  logic low_speed_recovery;
  logic [3:0] recovery_reserved;
  int error_cnt = 0;
  int checks_done = 0;
  int cyc = 0;
  logic [7:0] d;
  logic [5:0] last_class;
  logic [3:0] last_strobe;
  logic last_idx;
  logic [5:0] idx_tab [0:6] = '{6'h02, 6'h04, 6'h06, 6'h09, 6'h0B, 6'h00, 6'h1E};

  usb_indirect_register_port DUT (
    .sys_clk(sys_clk), .srst(srst), .sfr_req(sfr_req), .sfr_rdata(sfr_rdata),
    .speed_select(speed_select), .int_access(int_access), .int_rdata(int_rdata),
    .endpoint_index(endpoint_index), .indexed_access(indexed_access),
    .fifo_strobe(fifo_strobe), .target_class(target_class), .full_speed(full_speed),
    .recovery_enable(recovery_enable), .single_step_calibrate(single_step_calibrate),
    .low_speed_recovery(low_speed_recovery), .recovery_reserved(recovery_reserved)
  );

  usb_regspace_model far_side (
    .sys_clk(sys_clk), .int_access(int_access), .endpoint_index(endpoint_index),
    .indexed_access(indexed_access), .fifo_strobe(fifo_strobe), .int_rdata(int_rdata)
  );

  always #12.5 sys_clk = ~sys_clk;

  // Access pulses last one cycle, so latch what the port showed with each of them.
  always @(negedge sys_clk) begin
    if (int_access.read || int_access.write) begin
      last_class <= target_class;
      last_strobe <= fifo_strobe;
      last_idx <= indexed_access;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic finish_test;
    $display("checks %0d mismatches %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : finish_test

  // The whole run needs well under a few thousand cycles.
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      finish_test();
    end
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] v);
    @(negedge sys_clk);
    sfr_req.wr = 1'b1;
    sfr_req.addr = a;
    sfr_req.wdata = v;
    @(negedge sys_clk);
    sfr_req.wr = 1'b0;
  endtask : sfr_wr

  task automatic sfr_rd(input logic [7:0] a, output logic [7:0] v);
    @(negedge sys_clk);
    sfr_req.rd = 1'b1;
    sfr_req.addr = a;
    @(negedge sys_clk);
    sfr_req.rd = 1'b0;
    v = sfr_rdata;
  endtask : sfr_rd

  task automatic poll_idle;
    logic [7:0] v;
    for (int k = 0; k < 20; k++) begin
      sfr_rd(usb_port_pkg::ADDR_PORT_SFR, v);
      if (v[usb_port_pkg::BUSY_BIT] === 1'b0) begin
        return;
      end
    end
    check(v, 8'h00);
  endtask : poll_idle

  task automatic ind_rd(input logic [5:0] idx, input logic ar, output logic [7:0] v);
    poll_idle();
    sfr_wr(usb_port_pkg::ADDR_PORT_SFR, {1'b1, ar, idx});
    poll_idle();
    sfr_rd(usb_port_pkg::DATA_PORT_SFR, v);
  endtask : ind_rd

  task automatic ind_wr(input logic [5:0] idx, input logic [7:0] v);
    poll_idle();
    sfr_wr(usb_port_pkg::ADDR_PORT_SFR, {2'b00, idx});
    sfr_wr(usb_port_pkg::DATA_PORT_SFR, v);
  endtask : ind_wr

  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (10) @(negedge sys_clk);
    srst = 1'b0;
    sfr_rd(usb_port_pkg::ADDR_PORT_SFR, d);
    check(d, 8'h00);
    check({4'h0, recovery_reserved}, 8'h0F);
    ind_rd(usb_port_pkg::CLK_RECOVERY_IDX, 1'b0, d);
    check(d, 8'h0F);
    ind_rd(usb_port_pkg::EP_SELECT_IDX, 1'b0, d);
    check(d, 8'h00);
    $display("test reset done");
    ind_wr(usb_port_pkg::EP_SELECT_IDX, 8'hF2);
    ind_rd(usb_port_pkg::EP_SELECT_IDX, 1'b0, d);
    check(d, 8'h02);
    check({6'h00, endpoint_index}, 8'h02);
    for (int e = 0; e < 4; e++) begin
      ind_wr(usb_port_pkg::EP_SELECT_IDX, 8'(e));
      ind_wr(6'h12, 8'h10 + 8'(e));
    end
    for (int e = 3; e >= 0; e--) begin
      ind_wr(usb_port_pkg::EP_SELECT_IDX, 8'(e));
      ind_rd(6'h12, 1'b0, d);
      check(d, 8'h10 + 8'(e));
    end
    check({7'h00, last_idx}, 8'h01);
    check({2'b00, last_class}, 8'h08);
    ind_wr(usb_port_pkg::EP_SELECT_IDX, 8'h05);
    ind_rd(usb_port_pkg::EP_SELECT_IDX, 1'b0, d);
    check(d, 8'h05);
    ind_rd(6'h12, 1'b0, d);
    check({7'h00, last_idx}, 8'h00);
    $display("test endpoint select done");
    for (int i = 0; i < 7; i++) begin
      ind_rd(idx_tab[i], 1'b0, d);
      check(d, {2'b00, idx_tab[i]} ^ 8'hA5);
      ind_wr(idx_tab[i], 8'h30 + 8'(i));
      poll_idle();
      sfr_wr(usb_port_pkg::DATA_PORT_SFR, 8'hC0 + 8'(i));
      ind_rd(idx_tab[i], 1'b0, d);
      check(d, 8'hC0 + 8'(i));
    end
    sfr_rd(usb_port_pkg::ADDR_PORT_SFR, d);
    check(d, 8'h1E);
    $display("test map done");
    ind_rd(6'h21, 1'b1, d);
    check(d, 8'h40);
    poll_idle();
    sfr_rd(usb_port_pkg::DATA_PORT_SFR, d);
    check(d, 8'h41);
    poll_idle();
    sfr_rd(usb_port_pkg::ADDR_PORT_SFR, d);
    check(d, 8'h61);
    ind_rd(6'h22, 1'b0, d);
    check(d, 8'h43);
    sfr_rd(usb_port_pkg::DATA_PORT_SFR, d);
    check(d, 8'h43);
    ind_rd(6'h23, 1'b0, d);
    check(d, 8'h44);
    check({4'h0, last_strobe}, 8'h08);
    check({2'b00, last_class}, 8'h10);
    $display("test auto read done");
    poll_idle();
    sfr_wr(usb_port_pkg::ADDR_PORT_SFR, 8'h89);
    sfr_rd(usb_port_pkg::ADDR_PORT_SFR, d);
    check(d, 8'h89);
    poll_idle();
    sfr_wr(usb_port_pkg::ADDR_PORT_SFR, 8'h89);
    // This write meets the last busy cycle of the read just launched and must be dropped.
    sfr_wr(usb_port_pkg::DATA_PORT_SFR, 8'hEE);
    poll_idle();
    sfr_rd(usb_port_pkg::DATA_PORT_SFR, d);
    check(d, 8'hC3);
    ind_rd(6'h09, 1'b0, d);
    check(d, 8'hC3);
    $display("test busy refusal done");
    ind_wr(usb_port_pkg::CLK_RECOVERY_IDX, 8'hEF);
    check({5'h00, recovery_enable, single_step_calibrate, low_speed_recovery}, 8'h07);
    ind_wr(usb_port_pkg::CLK_RECOVERY_IDX, 8'hAF);
    check({5'h00, recovery_enable, single_step_calibrate, low_speed_recovery}, 8'h05);
    ind_rd(usb_port_pkg::CLK_RECOVERY_IDX, 1'b0, d);
    check(d, 8'hAF);
    $display("test clock recovery done");
    speed_select = 1'b1;
    repeat (4) @(negedge sys_clk);
    check({7'h00, full_speed}, 8'h01);
    speed_select = 1'b0;
    repeat (4) @(negedge sys_clk);
    check({7'h00, full_speed}, 8'h00);
    $display("test speed done");
    finish_test();
  end
endmodule : tb_top

// >>> verification/usb_regspace_model.sv
// Behavioural model of the controller's internal register space behind the indirect port.
`timescale 1ns/1ps

module usb_regspace_model (
  // Clock
  input wire logic sys_clk,
  // Access from the port
  input wire usb_port_pkg::int_access_t int_access,
  input wire logic [1:0] endpoint_index,
  input wire logic indexed_access,
  input wire logic [3:0] fifo_strobe,
  output logic [7:0] int_rdata
);
  logic [7:0] mem [0:255];
  logic [7:0] rd_val;
  logic [7:0] fifo_cnt;
  logic [7:0] live;
  logic [1:0] win;
  logic [7:0] key;

  initial begin
    for (int i = 0; i < 256; i++) begin
      mem[i] = 8'(i) ^ 8'hA5;
    end
    rd_val = 8'h00;
    fifo_cnt = 8'h40;
    win = 2'h0;
  end

  // Indexed registers get one bank per endpoint; everything else lives in bank zero.
  assign key = {(indexed_access ? endpoint_index : 2'h0), int_access.target};
  // A FIFO port hands out a new byte on every read, so repeated reads are visible.
  assign live = (|fifo_strobe) ? fifo_cnt : mem[key];
  // Outside the hold window the data lines show the inverse, never a stale match.
  assign int_rdata = int_access.read ? live : ((win != 2'h0) ? rd_val : ~rd_val);

  ////////////////////////////////////////////////////////////////////////////////
  // The space runs on the port's own clock, so it is always clocked during an access.
  always @(posedge sys_clk) begin
    if (int_access.write) begin
      mem[key] <= int_access.data;
    end
    if (int_access.read) begin
      rd_val <= live;
      win <= 2'h3;
      if (|fifo_strobe) begin
        fifo_cnt <= fifo_cnt + 8'h01;
      end
    end else if (win != 2'h0) begin
      win <= win - 2'h1;
    end
  end
endmodule : usb_regspace_model

// >>> verilog/usb_indirect_register_port.sv
// Indirect register port between the core's special-function bus and the USB controller.
`timescale 1ns/1ps

////////////////////////////////////////////////////////////////////////////////
// Notes on behaviour
// R1: Internal registers are reached only via the address port's 6-bit target field.
// R2: Software selects the endpoint first; indexed accesses then go to that endpoint.
// R3: Selector codes 0 to 3 mean endpoints 0 to 3; 4 to 15 are reserved.
// R4: Selector bits 7:4 read zero and writes to them are dropped.
// R5: The USB clock must run whenever an internal register is accessed.
// R6: Busy reads 1 during an access, 0 when the data port is valid.
// R7: Writing busy as 1 starts a read; address and busy may go together.
// R8: Software waits for busy low before an access and before taking data.
// R9: With auto-read set, reading the data port starts the next read, same address.
// R10: Without auto-read, software writes busy for every read.
// R11: Writing the data port sends that byte to the selected internal register.
// R12: The target field keeps its value between accesses.
// R13: Flag registers at 0x02, 0x04, 0x06; enables at 0x07, 0x09, 0x0B.
// R14: Indexed registers 0x11 to 0x17 act on the selected endpoint.
// R15: FIFO ports at 0x20 to 0x23; function address 0x00, endpoint enable 0x1E.
// R16: The clock source gives 6 MHz at low speed and 48 MHz at full speed.
// R17: Communication speed follows the transceiver control speed select bit.
// R18: Clock recovery trims the oscillator from incoming data stream timing.
// R19: Recovery is advised for full speed and low speed from the internal oscillator.
// R20: Low speed with recovery needs the low speed recovery bit set.
// R21: Single-step calibration is an optional recovery mode for noisy buses.
// R22: Speed select 1 means full speed, 0 means low speed.
// R23: Recovery enable bit 7 turns clock recovery on when 1.
// R24: Busy rises at a read's start and falls only once captured data is stable.
module usb_indirect_register_port (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic srst,
  // Special-function register bus
  input wire usb_port_pkg::sfr_req_t sfr_req,
  output logic [7:0] sfr_rdata,
  // Speed select from the transceiver control register
  input wire logic speed_select,
  // Internal register space of the controller
  output usb_port_pkg::int_access_t int_access,
  input wire logic [7:0] int_rdata,
  output logic [1:0] endpoint_index,
  output logic indexed_access,
  output logic [3:0] fifo_strobe,
  output logic [5:0] target_class,
  // Clock recovery controls
  output logic full_speed,
  output logic recovery_enable,
  output logic single_step_calibrate,
  output logic low_speed_recovery,
  output logic [3:0] recovery_reserved
);

  // Decodes an internal address into a one-hot class:
  // 0 flags, 1 enables, 2 function address and endpoint enable, 3 indexed, 4 fifo, 5 local.
  function automatic logic [5:0] classify(input logic [5:0] a);
    logic [5:0] c;
    c = 6'h00;
    if (a == usb_port_pkg::IN_FLAGS_IDX || a == usb_port_pkg::OUT_FLAGS_IDX ||
        a == usb_port_pkg::COMMON_FLAGS_IDX) begin
      c[0] = 1'b1; // R13
    end else if (a == usb_port_pkg::IN_ENABLES_IDX || a == usb_port_pkg::OUT_ENABLES_IDX ||
        a == usb_port_pkg::COMMON_ENABLES_IDX) begin
      c[1] = 1'b1; // R13
    end else if (a == usb_port_pkg::FUNC_ADDR_IDX || a == usb_port_pkg::EP_ENABLE_IDX) begin
      c[2] = 1'b1; // R15
    end else if (a >= usb_port_pkg::INDEXED_LO_IDX && a <= usb_port_pkg::INDEXED_HI_IDX) begin
      c[3] = 1'b1; // R14
    end else if (a >= usb_port_pkg::FIFO_LO_IDX && a <= usb_port_pkg::FIFO_HI_IDX) begin
      c[4] = 1'b1; // R15
    end else if (a == usb_port_pkg::EP_SELECT_IDX || a == usb_port_pkg::CLK_RECOVERY_IDX) begin
      c[5] = 1'b1;
    end
    return c;
  endfunction : classify

  ////////////////////////////////////////////////////////////////////////////////
  // Register state

  logic busy_reg, busy_next;
  logic auto_read_reg, auto_read_next;
  logic [5:0] target_reg, target_next;
  logic [7:0] data_reg, data_next;
  logic [3:0] ep_select_reg, ep_select_next;
  logic [7:0] clk_rec_reg, clk_rec_next;
  logic [1:0] count_reg, count_next;
  logic speed_meta_reg, speed_reg;
  usb_port_pkg::access_state_t state_reg, state_next;
  usb_port_pkg::int_access_t access_reg, access_next;
  logic [7:0] rdata_reg, rdata_next;

  logic addr_wr, data_wr, data_rd, addr_rd;
  logic start_read, local_target;
  logic [7:0] local_rdata;

  assign addr_wr = sfr_req.wr && sfr_req.addr == usb_port_pkg::ADDR_PORT_SFR;
  assign data_wr = sfr_req.wr && sfr_req.addr == usb_port_pkg::DATA_PORT_SFR;
  assign addr_rd = sfr_req.rd && sfr_req.addr == usb_port_pkg::ADDR_PORT_SFR;
  assign data_rd = sfr_req.rd && sfr_req.addr == usb_port_pkg::DATA_PORT_SFR;
  assign local_target = target_reg == usb_port_pkg::EP_SELECT_IDX ||
      target_reg == usb_port_pkg::CLK_RECOVERY_IDX;

  // A read starts on a busy write, or on a data read when auto-read is on.
  // Requests made while busy are dropped, since the data port would be torn.
  always_comb begin
    start_read = 1'b0;
    if (!busy_reg) begin
      if (addr_wr && sfr_req.wdata[usb_port_pkg::BUSY_BIT]) begin
        start_read = 1'b1; // R7
      end else if (data_rd && auto_read_reg) begin
        start_read = 1'b1; // R9
      end
    end
  end

  always_comb begin
    local_rdata = usb_port_pkg::ZERO_BYTE;
    if (target_reg == usb_port_pkg::EP_SELECT_IDX) begin
      local_rdata = {4'h0, ep_select_reg}; // R4
    end else if (target_reg == usb_port_pkg::CLK_RECOVERY_IDX) begin
      local_rdata = clk_rec_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Access sequencer

  always_comb begin
    busy_next = busy_reg;
    auto_read_next = auto_read_reg;
    target_next = target_reg; // R12
    data_next = data_reg;
    ep_select_next = ep_select_reg;
    clk_rec_next = clk_rec_reg;
    count_next = count_reg;
    state_next = state_reg;
    access_next = '0;
    if (addr_wr && !busy_reg) begin
      auto_read_next = sfr_req.wdata[usb_port_pkg::AUTO_READ_BIT];
      target_next = sfr_req.wdata[usb_port_pkg::TARGET_MSB:0]; // R1
    end
    unique case (state_reg)
      usb_port_pkg::ST_IDLE: begin
        if (start_read) begin
          busy_next = 1'b1; // R6 R24
          state_next = usb_port_pkg::ST_READ;
          count_next = usb_port_pkg::ACCESS_CYCLES;
          access_next.read = 1'b1;
          access_next.target = addr_wr ? sfr_req.wdata[usb_port_pkg::TARGET_MSB:0] : target_reg;
        end else if (data_wr) begin
          busy_next = 1'b1;
          data_next = sfr_req.wdata;
          state_next = usb_port_pkg::ST_WRITE;
          count_next = usb_port_pkg::ACCESS_CYCLES;
          access_next.write = 1'b1; // R11
          access_next.target = target_reg;
          access_next.data = sfr_req.wdata;
          if (target_reg == usb_port_pkg::EP_SELECT_IDX) begin
            ep_select_next = sfr_req.wdata[usb_port_pkg::EP_FIELD_MSB:0]; // R2 R4
          end else if (target_reg == usb_port_pkg::CLK_RECOVERY_IDX) begin
            clk_rec_next = sfr_req.wdata;
          end
        end
      end
      usb_port_pkg::ST_READ: begin
        count_next = count_reg - 2'h1;
        if (count_reg == 2'h1) begin
          // Capture on the last cycle so the value has settled before busy falls.
          data_next = local_target ? local_rdata : int_rdata; // R24
          busy_next = 1'b0; // R6
          state_next = usb_port_pkg::ST_IDLE;
        end
      end
      usb_port_pkg::ST_WRITE: begin
        count_next = count_reg - 2'h1;
        if (count_reg == 2'h1) begin
          busy_next = 1'b0;
          state_next = usb_port_pkg::ST_IDLE;
        end
      end
      default: begin
        busy_next = 1'b0;
        state_next = usb_port_pkg::ST_IDLE;
      end
    endcase
  end

  always_comb begin
    rdata_next = usb_port_pkg::ZERO_BYTE;
    if (addr_rd) begin
      rdata_next = {busy_reg, auto_read_reg, target_reg}; // R6
    end else if (data_rd) begin
      rdata_next = data_reg;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (srst) begin
      busy_reg <= 1'b0;
      auto_read_reg <= 1'b0;
      target_reg <= 6'h00;
      data_reg <= usb_port_pkg::ZERO_BYTE;
      ep_select_reg <= 4'h0;
      clk_rec_reg <= usb_port_pkg::CLK_RECOVERY_RESET;
      count_reg <= 2'h0;
      state_reg <= usb_port_pkg::ST_IDLE;
      access_reg <= '0;
      rdata_reg <= usb_port_pkg::ZERO_BYTE;
    end else begin
      busy_reg <= busy_next;
      auto_read_reg <= auto_read_next;
      target_reg <= target_next;
      data_reg <= data_next;
      ep_select_reg <= ep_select_next;
      clk_rec_reg <= clk_rec_next;
      count_reg <= count_next;
      state_reg <= state_next;
      access_reg <= access_next;
      rdata_reg <= rdata_next;
    end
  end

  // The speed bit belongs to another register block; treat it as asynchronous.
  always_ff @(posedge sys_clk) begin
    if (srst) begin
      speed_meta_reg <= 1'b0;
      speed_reg <= 1'b0;
    end else begin
      speed_meta_reg <= speed_select;
      speed_reg <= speed_meta_reg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs

  logic [5:0] cls;
  assign cls = classify(access_reg.target);
  assign int_access = access_reg;
  assign sfr_rdata = rdata_reg;
  assign target_class = cls;
  // Reserved selector codes reach no endpoint; indexed_access stays low for them.
  assign indexed_access = cls[3] && ep_select_reg <= usb_port_pkg::EP_LAST_CODE; // R3 R14
  assign endpoint_index = ep_select_reg[1:0]; // R2

  genvar g;
  generate
    for (g = 0; g < usb_port_pkg::NUM_EP; g++) begin : g_fifo
      assign fifo_strobe[g] = cls[4] && (access_reg.read || access_reg.write) &&
          access_reg.target[1:0] == 2'(g); // R15
    end
  endgenerate

  assign full_speed = speed_reg; // R17 R22
  // Trimming itself lives in the oscillator; it consumes these controls.
  assign recovery_enable = clk_rec_reg[usb_port_pkg::RECOVERY_EN_BIT]; // R18 R23
  assign single_step_calibrate = clk_rec_reg[usb_port_pkg::SINGLE_STEP_BIT]; // R21
  assign low_speed_recovery = clk_rec_reg[usb_port_pkg::LOW_SPEED_REC_BIT];
  assign recovery_reserved = clk_rec_reg[3:0];

  ////////////////////////////////////////////////////////////////////////////////
  // Assertions

  property p_busy_on_read;
    @(posedge sys_clk) disable iff (srst)
      start_read |=> busy_reg && access_reg.read;
  endproperty
  a_busy_on_read: assert property (p_busy_on_read) else $error("busy not set on read"); // R7

  property p_busy_length;
    @(posedge sys_clk) disable iff (srst)
      $rose(busy_reg) |-> busy_reg [*2] ##1 !busy_reg;
  endproperty
  a_busy_length: assert property (p_busy_length) else $error("busy length wrong"); // R6

  property p_capture;
    @(posedge sys_clk) disable iff (srst)
      (state_reg == usb_port_pkg::ST_READ && count_reg == 2'h1 && !local_target)
        |=> data_reg == $past(int_rdata) && !busy_reg;
  endproperty
  a_capture: assert property (p_capture) else $error("read data not captured"); // R24

  property p_auto_read;
    @(posedge sys_clk) disable iff (srst)
      (data_rd && auto_read_reg && !busy_reg) |=> access_reg.read &&
        access_reg.target == $past(target_reg);
  endproperty
  a_auto_read: assert property (p_auto_read) else $error("auto read missing"); // R9

  property p_write;
    @(posedge sys_clk) disable iff (srst)
      (data_wr && !busy_reg && !start_read) |=> access_reg.write &&
        access_reg.data == $past(sfr_req.wdata) && access_reg.target == $past(target_reg);
  endproperty
  a_write: assert property (p_write) else $error("write not forwarded"); // R11

  property p_target_hold;
    @(posedge sys_clk) disable iff (srst)
      !addr_wr |=> $stable(target_reg);
  endproperty
  a_target_hold: assert property (p_target_hold) else $error("target changed"); // R12

  property p_sel_upper;
    @(posedge sys_clk) disable iff (srst)
      ep_select_reg == $past(ep_select_reg) || $past(data_wr) &&
        ep_select_reg == $past(sfr_req.wdata[3:0]);
  endproperty
  a_sel_upper: assert property (p_sel_upper) else $error("selector bad update"); // R4

  property p_indexed_reserved;
    @(posedge sys_clk) disable iff (srst)
      ep_select_reg > usb_port_pkg::EP_LAST_CODE |-> !indexed_access;
  endproperty
  a_indexed_reserved: assert property (p_indexed_reserved) else $error("reserved ep used"); // R3

  property p_fifo_decode;
    @(posedge sys_clk) disable iff (srst)
      access_reg.read && access_reg.target == usb_port_pkg::FIFO_HI_IDX |-> fifo_strobe == 4'h8;
  endproperty
  a_fifo_decode: assert property (p_fifo_decode) else $error("fifo decode wrong"); // R15

  // A data write that meets a busy port must not reach the register space.
  property p_busy_refuse;
    @(posedge sys_clk) disable iff (srst)
      (data_wr && busy_reg) |=> !access_reg.write;
  endproperty
  a_busy_refuse: assert property (p_busy_refuse) else $error("write taken while busy"); // R6

  property p_sel_read_zero;
    @(posedge sys_clk) disable iff (srst)
      (state_reg == usb_port_pkg::ST_READ && count_reg == 2'h1 &&
        target_reg == usb_port_pkg::EP_SELECT_IDX) |=> data_reg[7:4] == 4'h0;
  endproperty
  a_sel_read_zero: assert property (p_sel_read_zero) else $error("selector top bits set"); // R4

  property p_fifo_onehot;
    @(posedge sys_clk) disable iff (srst)
      (access_reg.read || access_reg.write) && cls[4] |-> $onehot(fifo_strobe);
  endproperty
  a_fifo_onehot: assert property (p_fifo_onehot) else $error("fifo strobe not one-hot"); // R15

  property p_recovery_write;
    @(posedge sys_clk) disable iff (srst)
      (data_wr && !busy_reg && !start_read && target_reg == usb_port_pkg::CLK_RECOVERY_IDX)
        |=> clk_rec_reg == $past(sfr_req.wdata);
  endproperty
  a_recovery_write: assert property (p_recovery_write) else $error("recovery not written"); // R23

endmodule : usb_indirect_register_port
